// File: rtl/led_panel_config_intensity.sv
// Overview of operation
// - colour bit D6 set means the panel uses red-green-yellow bicolour digits.
// - colour bit clear means single-colour or RGB digits.
// - reduced variants hold the colour bit at zero; writes ignored.
// - depth bit D7 clear gives four one-bit planes, 0 to 3.
// - depth bit set gives planes 0 and 1 with two-bit four-level pixels.
// - arithmetic scale: 10 skips frames mod 3 equal 1; 01 lights only those.
// - geometric scale: 10 lights even frames; 01 lights frames mod 4 equal 1.
// - digit 0 brightness register at 0x03 sets n/256 fraction.
// - digit 1 brightness register at 0x04 sets n/256 fraction.
// - bits D3:D2 report the plane code captured from CUR_PLANE at the last frame end.
// - plane code bits are read-only; writes to them are dropped.
// - staggered sync offsets each chained driver by one OSC/4 period.
// - alternate timing reverses PWM timing on odd-address drivers.
// - plane codes 00/01/10/11; in two-plane mode 10 and 11 mean 0 and 1.
// - arithmetic or geometric scale is chosen separately per digit.
// - digit duty equals n/256 times the panel intensity.
`timescale 1ns/10ps
module led_panel_config_intensity #(
  parameter bit COLOR_LOCKED = 1'b0,
  parameter bit DEPTH_LOCKED = 1'b0,
  parameter int PWM_STEP_CYC = led_cfg_pkg::PWM_STEP_CYCLES,
  parameter int RIPPLE_STEP_CYC = led_cfg_pkg::RIPPLE_STEP_CYCLES,
  parameter int FRAME_PERIODS = led_cfg_pkg::PERIODS_PER_FRAME
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [led_cfg_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [led_cfg_pkg::DATA_W-1:0] REG_WDATA,
  output logic [led_cfg_pkg::DATA_W-1:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [7:0] PANEL_LEVEL,
  input wire logic [7:0] DRIVER_ADDR,
  input wire logic RESYNC,
  input wire logic [1:0] CUR_PLANE,
  input wire logic [1:0] PIX0,
  input wire logic [1:0] PIX1,
  input wire logic [1:0] GRAD_GEOM,
  output logic DIGIT0_ON,
  output logic DIGIT1_ON,
  output logic FRAME_START,
  output logic [3:0] FRAME_INDEX,
  output logic PANEL_RGY,
  output logic PLANE_TWO_BIT,
  output logic MUX_FLIPPED
);
  import led_cfg_pkg::*;

  localparam logic [15:0] STEP_LAST = 16'(PWM_STEP_CYC - 1);
  localparam logic [15:0] RIPPLE_LAST = 16'(RIPPLE_STEP_CYC - 1);
  localparam logic [3:0] PERIOD_LAST = 4'(FRAME_PERIODS - 1);
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_CYCLE_LEN - 1);

  // register file
  logic [7:0] digit0_q, digit0_d, digit1_q, digit1_d, setup_q, setup_d;
  logic [7:0] cfg_act_q, cfg_act_d, rdata_q, rdata_d;
  logic [1:0] plane_q, plane_d;
  logic rvalid_q, rvalid_d;
  // sequencer
  seq_state_t state_q, state_d;
  logic [15:0] step_q, step_d;
  logic [7:0] addr_left_q, addr_left_d, pwm_q, pwm_d;
  logic [3:0] period_q, period_d, frame_q, frame_d;
  logic frame_end, fstart_q, fstart_d, on0_q, on0_d, on1_q, on1_d;
  logic [15:0] prod0, prod1;
  logic lit0, lit1, flip_now;

  always_comb begin
    digit0_d = digit0_q;
    digit1_d = digit1_q;
    setup_d = setup_q;
    cfg_act_d = cfg_act_q;
    plane_d = plane_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (REG_WR) begin
      if (REG_ADDR == ADDR_DIGIT0) begin
        digit0_d = REG_WDATA;
      end else if (REG_ADDR == ADDR_DIGIT1) begin
        digit1_d = REG_WDATA;
      end else if (REG_ADDR == ADDR_SETUP) begin
        setup_d = REG_WDATA & SETUP_WMASK;
        if (COLOR_LOCKED) begin
          setup_d[BIT_COLOR] = 1'b0;
        end
        if (DEPTH_LOCKED) begin
          setup_d[BIT_DEPTH] = 1'b0;
        end
      end
    end
    // new setup settings other than the ripple bit only reach the display logic between frames; digit brightness writes act at once
    if (frame_end) begin
      cfg_act_d = setup_q;
      plane_d = CUR_PLANE;
    end
    if (REG_RD) begin
      rvalid_d = 1'b1;
      if (REG_ADDR == ADDR_DIGIT0) begin
        rdata_d = digit0_q;
      end else if (REG_ADDR == ADDR_DIGIT1) begin
        rdata_d = digit1_q;
      end else if (REG_ADDR == ADDR_SETUP) begin
        rdata_d = setup_q;
        rdata_d[BIT_PLANE_HI:BIT_PLANE_LO] = plane_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      digit0_q <= RST_DIGIT;
      digit1_q <= RST_DIGIT;
      setup_q <= RST_SETUP;
      cfg_act_q <= RST_SETUP;
      plane_q <= RST_PLANE;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      digit0_q <= digit0_d;
      digit1_q <= digit1_d;
      setup_q <= setup_d;
      cfg_act_q <= cfg_act_d;
      plane_q <= plane_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign frame_end = (state_q == ST_RUN) && (step_q == STEP_LAST) && (pwm_q == 8'hFF)
    && (period_q == PERIOD_LAST);
  assign prod0 = digit0_q * PANEL_LEVEL;
  assign prod1 = digit1_q * PANEL_LEVEL;
  assign flip_now = cfg_act_q[BIT_FLIP] && DRIVER_ADDR[0];

  // each digit has its own scale select
  pixel_modulator u_mod0 (
    .pix(PIX0),
    .two_bit(cfg_act_q[BIT_DEPTH]),
    .geom(GRAD_GEOM[0]),
    .frame_idx(frame_q),
    .thr(prod0[15:8]),
    .pwm_cnt(pwm_q),
    .flip(flip_now),
    .lit(lit0)
  );
  pixel_modulator u_mod1 (
    .pix(PIX1),
    .two_bit(cfg_act_q[BIT_DEPTH]),
    .geom(GRAD_GEOM[1]),
    .frame_idx(frame_q),
    .thr(prod1[15:8]),
    .pwm_cnt(pwm_q),
    .flip(flip_now),
    .lit(lit1)
  );

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    addr_left_d = addr_left_q;
    pwm_d = pwm_q;
    period_d = period_q;
    frame_d = frame_q;
    fstart_d = 1'b0;
    on0_d = 1'b0;
    on1_d = 1'b0;
    case (state_q)
      ST_DELAY: begin
        // one step per address below ours; the chain settles by itself
        if (addr_left_q == 8'h00) begin
          state_d = ST_RUN;
          step_d = 16'h0000;
          fstart_d = 1'b1;
        end else if (step_q == RIPPLE_LAST) begin
          step_d = 16'h0000;
          addr_left_d = addr_left_q - 8'h01;
        end else begin
          step_d = step_q + 16'h0001;
        end
      end
      ST_RUN: begin
        on0_d = lit0;
        on1_d = lit1;
        if (step_q == STEP_LAST) begin
          step_d = 16'h0000;
          pwm_d = pwm_q + 8'h01;
          if (pwm_q == 8'hFF) begin
            period_d = (period_q == PERIOD_LAST) ? 4'h0 : period_q + 4'h1;
          end
          if (frame_end) begin
            frame_d = (frame_q == FRAME_LAST) ? 4'h0 : frame_q + 4'h1;
            fstart_d = 1'b1;
          end
        end else begin
          step_d = step_q + 16'h0001;
        end
      end
      default: state_d = ST_RUN;
    endcase
    if (RESYNC) begin
      state_d = (setup_q[BIT_RIPPLE] && DRIVER_ADDR != 8'h00) ? ST_DELAY : ST_RUN;
      addr_left_d = setup_q[BIT_RIPPLE] ? DRIVER_ADDR : 8'h00;
      step_d = 16'h0000;
      pwm_d = 8'h00;
      period_d = 4'h0;
      on0_d = 1'b0;
      on1_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= ST_RUN;
      step_q <= 16'h0000;
      addr_left_q <= 8'h00;
      pwm_q <= 8'h00;
      period_q <= 4'h0;
      frame_q <= 4'h0;
      fstart_q <= 1'b0;
      on0_q <= 1'b0;
      on1_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      addr_left_q <= addr_left_d;
      pwm_q <= pwm_d;
      period_q <= period_d;
      frame_q <= frame_d;
      fstart_q <= fstart_d;
      on0_q <= on0_d;
      on1_q <= on1_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign DIGIT0_ON = on0_q;
  assign DIGIT1_ON = on1_q;
  assign FRAME_START = fstart_q;
  assign FRAME_INDEX = frame_q;
  assign PANEL_RGY = cfg_act_q[BIT_COLOR];
  assign PLANE_TWO_BIT = cfg_act_q[BIT_DEPTH];
  assign MUX_FLIPPED = flip_now;

  property p_plane_ro;
    @(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_ADDR == ADDR_SETUP && !frame_end) |=> (plane_q == $past(plane_q));
  endproperty
  a_plane_ro: assert property (p_plane_ro) else $error("plane code changed by write");
  property p_digit0_store;
    @(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_ADDR == ADDR_DIGIT0) |=> (digit0_q == $past(REG_WDATA));
  endproperty
  a_digit0_store: assert property (p_digit0_store) else $error("digit 0 not stored");
  property p_digit1_store;
    @(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_ADDR == ADDR_DIGIT1) ##1 !REG_WR
      ##1 (REG_RD && REG_ADDR == ADDR_DIGIT1 && !REG_WR) |=> (REG_RDATA == $past(REG_WDATA, 3));
  endproperty
  a_digit1_store: assert property (p_digit1_store) else $error("digit 1 readback wrong");
  property p_color_lock;
    @(posedge CLK) disable iff (!RST_N)
      (REG_WR && REG_ADDR == ADDR_SETUP) |=> (!COLOR_LOCKED || !setup_q[BIT_COLOR]);
  endproperty
  a_color_lock: assert property (p_color_lock) else $error("locked colour bit set");
  property p_frame_wrap;
    @(posedge CLK) disable iff (!RST_N)
      (frame_end && frame_q == FRAME_LAST && !RESYNC) |=> (frame_q == 4'h0 && FRAME_START);
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame index wrap wrong");
  property p_cfg_boundary;
    @(posedge CLK) disable iff (!RST_N)
      !frame_end |=> (cfg_act_q == $past(cfg_act_q));
  endproperty
  a_cfg_boundary: assert property (p_cfg_boundary) else $error("config changed mid-frame");
  property p_zero_dark;
    @(posedge CLK) disable iff (!RST_N)
      (digit0_q == 8'h00 || PANEL_LEVEL == 8'h00) |=> !DIGIT0_ON;
  endproperty
  a_zero_dark: assert property (p_zero_dark) else $error("digit lit at zero duty");
  property p_ripple_start;
    @(posedge CLK) disable iff (!RST_N)
      (RESYNC && !setup_q[BIT_RIPPLE]) |=> (state_q == ST_RUN) ##1 FRAME_START == 1'b0;
  endproperty
  a_ripple_start: assert property (p_ripple_start) else $error("no-ripple resync delayed");
  property p_plane_read;
    @(posedge CLK) disable iff (!RST_N)
      (REG_RD && REG_ADDR == ADDR_SETUP)
      |=> (REG_RVALID && REG_RDATA[BIT_PLANE_HI:BIT_PLANE_LO] == $past(plane_q));
  endproperty
  a_plane_read: assert property (p_plane_read) else $error("plane code misreported");
endmodule : led_panel_config_intensity

// File: common/led_cfg_pkg.sv
package led_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_DIGIT0 = 8'h03;
  localparam logic [7:0] ADDR_DIGIT1 = 8'h04;
  localparam logic [7:0] ADDR_SETUP = 8'h0D;
  localparam int BIT_SHUTDOWN = 0;
  localparam int BIT_INVERT = 1;
  localparam int BIT_PLANE_LO = 2;
  localparam int BIT_PLANE_HI = 3;
  localparam int BIT_RIPPLE = 4;
  localparam int BIT_FLIP = 5;
  localparam int BIT_COLOR = 6;
  localparam int BIT_DEPTH = 7;
  localparam logic [7:0] SETUP_WMASK = 8'hF3;
  localparam logic [7:0] RST_DIGIT = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [1:0] RST_PLANE = 2'h0;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DIGIT_PERIOD_PS = 122000000;
  localparam int PWM_STEPS = 256;
  localparam int PWM_STEP_CYCLES = DIGIT_PERIOD_PS / (PWM_STEPS * CLK_PERIOD_PS);
  localparam int RIPPLE_STEP_PS = 953700;
  localparam int RIPPLE_STEP_CYCLES = (RIPPLE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PERIODS_PER_FRAME = 8;
  localparam int FRAME_CYCLE_LEN = 12;
  typedef enum logic [1:0] {
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;
endpackage : led_cfg_pkg

// File: rtl/pixel_modulator.sv
`timescale 1ns/10ps
module pixel_modulator (
  input wire logic [1:0] pix,
  input wire logic two_bit,
  input wire logic geom,
  input wire logic [3:0] frame_idx,
  input wire logic [7:0] thr,
  input wire logic [7:0] pwm_cnt,
  input wire logic flip,
  output logic lit
);
  logic frame_on;
  logic pwm_on;
  logic [7:0] cnt_eff;
  always_comb begin
    frame_on = pix[0];
    if (two_bit) begin
      case (pix)
        2'b11: frame_on = 1'b1;
        2'b10: frame_on = geom ? !frame_idx[0] : ((frame_idx % 4'd3) != 4'd1);
        2'b01: frame_on = geom ? (frame_idx[1:0] == 2'd1) : ((frame_idx % 4'd3) == 4'd1);
        default: frame_on = 1'b0;
      endcase
    end
    // flipped timing lights at the end of the period instead of the start
    cnt_eff = flip ? ~pwm_cnt : pwm_cnt;
    pwm_on = cnt_eff < thr;
    lit = frame_on && pwm_on;
  end
endmodule : pixel_modulator

// File: sim/host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model (
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'hFF;
    wdata = 8'hFF;
  end
  // released bus shows inverted values so a stale sample cannot pass
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = (rvalid === 1'b1) ? rdata : ~rdata;
  endtask : read_reg
endmodule : host_bus_model

// File: sim/tb.sv
`timescale 1ns/10ps
module tb;
  import led_cfg_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic wr, rd, rvalid, resync, d0_on, d1_on, fs, rgy, two_bit, flipped;
  logic [7:0] addr, wdata, rdata, rdata2, level, drv_addr, v;
  logic [1:0] cur_plane, pix0, pix1, geom;
  logic [3:0] fidx;
  int n_fail = 0;
  int comparisons = 0;
  always #2 CLK = ~CLK;
  host_bus_model host (.clk(CLK), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));
  led_panel_config_intensity #(.PWM_STEP_CYC(1), .RIPPLE_STEP_CYC(2), .FRAME_PERIODS(1)) dut (
    .CLK(CLK), .RST_N(RST_N), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .PANEL_LEVEL(level), .DRIVER_ADDR(drv_addr),
    .RESYNC(resync), .CUR_PLANE(cur_plane), .PIX0(pix0), .PIX1(pix1), .GRAD_GEOM(geom),
    .DIGIT0_ON(d0_on), .DIGIT1_ON(d1_on), .FRAME_START(fs), .FRAME_INDEX(fidx),
    .PANEL_RGY(rgy), .PLANE_TWO_BIT(two_bit), .MUX_FLIPPED(flipped));
  // reduced variant shares the bus; only its read data is watched, so default timing will do
  led_panel_config_intensity #(.COLOR_LOCKED(1'b1), .DEPTH_LOCKED(1'b1)) dut_locked (
    .CLK(CLK), .RST_N(RST_N), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata2), .REG_RVALID(), .PANEL_LEVEL(level), .DRIVER_ADDR(drv_addr),
    .RESYNC(resync), .CUR_PLANE(cur_plane), .PIX0(pix0), .PIX1(pix1), .GRAD_GEOM(geom),
    .DIGIT0_ON(), .DIGIT1_ON(), .FRAME_START(), .FRAME_INDEX(), .PANEL_RGY(),
    .PLANE_TWO_BIT(), .MUX_FLIPPED());
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // returns one cycle after a frame start pulse
  task automatic wait_frame;
    int k;
    for (k = 0; k < 2000 && fs !== 1'b1; k++) @(negedge CLK);
    check({7'h00, fs}, 8'h01);
    @(negedge CLK);
  endtask : wait_frame
  function automatic logic lit(input logic [1:0] px, input logic g, input logic [3:0] i);
    case (px)
      2'b11: return 1'b1;
      2'b10: return g ? (i % 2 == 0) : (i % 3 != 1);
      2'b01: return g ? (i % 4 == 1) : (i % 3 == 1);
      default: return 1'b0;
    endcase
  endfunction : lit
  task automatic t_regs;
    host.read_reg(ADDR_DIGIT1, v);
    check(v, RST_DIGIT);
    host.write_reg(ADDR_DIGIT0, 8'hA5);
    host.read_reg(ADDR_DIGIT0, v);
    check(v, 8'hA5);
    host.write_reg(ADDR_DIGIT1, 8'h5A);
    host.read_reg(ADDR_DIGIT1, v);
    check(v, 8'h5A);
    host.write_reg(8'h05, 8'hFF);
    host.read_reg(8'h05, v);
    check(v, 8'h00);
    host.write_reg(ADDR_SETUP, 8'h0C);
    host.read_reg(ADDR_SETUP, v);
    check(v, 8'h00);
  endtask : t_regs
  task automatic t_cfg;
    host.write_reg(ADDR_SETUP, 8'hC0);
    host.read_reg(ADDR_SETUP, v);
    check(v, 8'hC0);
    check(rdata2, 8'h00);
    wait_frame;
    check({6'h00, rgy, two_bit}, 8'h03);
    host.write_reg(ADDR_SETUP, 8'h80);
    check({6'h00, rgy, two_bit}, 8'h03);
    wait_frame;
    check({6'h00, rgy, two_bit}, 8'h01);
  endtask : t_cfg
  task automatic t_plane;
    cur_plane = 2'h3;
    host.write_reg(ADDR_SETUP, 8'h00);
    wait_frame;
    wait_frame;
    host.read_reg(ADDR_SETUP, v);
    check(v, 8'h0C);
    check({7'h00, two_bit}, 8'h00);
    cur_plane = 2'h2;
    host.write_reg(ADDR_SETUP, 8'h80);
    wait_frame;
    wait_frame;
    host.read_reg(ADDR_SETUP, v);
    check(v, 8'h88);
  endtask : t_plane
  task automatic t_mod;
    int p, f;
    logic [3:0] nx;
    logic [1:0] pv[3] = '{2'b10, 2'b01, 2'b11};
    host.write_reg(ADDR_DIGIT0, 8'hFF);
    host.write_reg(ADDR_DIGIT1, 8'hFF);
    level = 8'hFF;
    for (p = 0; p < 3; p++) begin
      pix0 = pv[p];
      pix1 = (p == 2) ? 2'b00 : pv[p];
      geom = (p == 1) ? 2'b01 : 2'b10;
      for (f = 0; f < 12; f++) begin
        wait_frame;
        @(negedge CLK);
        check({7'h00, d0_on}, {7'h00, lit(pix0, geom[0], fidx)});
        check({7'h00, d1_on}, {7'h00, lit(pix1, geom[1], fidx)});
        if (f > 0 || p > 0) check({4'h0, fidx}, {4'h0, nx});
        nx = (fidx == 4'hB) ? 4'h0 : fidx + 4'h1;
      end
    end
  endtask : t_mod
  task automatic t_pwm;
    int k;
    logic [7:0] c0, c1;
    host.write_reg(ADDR_DIGIT0, 8'h80);
    host.write_reg(ADDR_DIGIT1, 8'h00);
    pix1 = 2'b11;
    wait_frame;
    c0 = 8'h00;
    c1 = 8'h00;
    for (k = 0; k < 256; k++) begin
      @(negedge CLK);
      c0 += {7'h00, d0_on};
      c1 += {7'h00, d1_on};
    end
    // 0x80 of 0xFF panel level: 0x7F lit steps per period
    check(c0, 8'h7F);
    check(c1, 8'h00);
  endtask : t_pwm
  task automatic t_sync;
    int k;
    host.write_reg(ADDR_SETUP, 8'hB0);
    drv_addr = 8'h01;
    wait_frame;
    check({7'h00, flipped}, 8'h01);
    drv_addr = 8'h02;
    @(negedge CLK);
    check({7'h00, flipped}, 8'h00);
    resync = 1'b1;
    @(negedge CLK);
    resync = 1'b0;
    for (k = 1; k < 40 && fs !== 1'b1; k++) @(negedge CLK);
    check(8'(k), 8'h06);
    // ripple off: no start delay, first frame start one full period (one step per cycle) later
    host.write_reg(ADDR_SETUP, 8'h00);
    resync = 1'b1;
    @(negedge CLK);
    resync = 1'b0;
    for (k = 1; k < 400 && fs !== 1'b1; k++) @(negedge CLK);
    check(8'(k), 8'(PWM_STEPS + 1));
  endtask : t_sync
  initial begin
    {resync, level, drv_addr, cur_plane, pix0, pix1} = '0;
    geom = 2'b10;
    repeat (10) @(negedge CLK);
    RST_N = 1'b1;
    t_regs;
    t_cfg;
    t_plane;
    t_mod;
    t_pwm;
    t_sync;
    complete_run;
  end
  // whole run needs about 12000 cycles
  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
endmodule : tb
